// ### core/axis_guard_params.svh
// Offsets, field positions, reset values and timing counts for the axis guard
`ifndef AXIS_GUARD_PARAMS_SVH
`define AXIS_GUARD_PARAMS_SVH
// Register byte offsets
`define OFS_LIMIT_FUNC 12'h000
`define OFS_FWD_LIMIT 12'h004
`define OFS_REV_LIMIT 12'h008
`define OFS_OUT_ALLOC 12'h00C
`define OFS_PWR_DELAY 12'h010
`define OFS_CONTROL 12'h014
`define OFS_STATUS 12'h018
`define OFS_POSITION 12'h01C
`define OFS_TARGET 12'h020
// Field positions inside the limit function setting
`define FLD_LIM_EN_LSB 0
`define FLD_REF_CHK_BIT 8
// Field position of the brake allocation digit
`define FLD_BK_ALLOC_LSB 8
// Reset values
`define RST_LIMIT_FUNC 32'h0000_0003
`define RST_FWD_LIMIT 32'h3FFF_FFFF
`define RST_REV_LIMIT 32'hC000_0001
`define RST_OUT_ALLOC 32'h0000_0100
`define RST_PWR_DELAY 32'h0000_0000
// Power-off delay step and clock
`define DELAY_STEP_MS 10
`define CLK_HZ 40000000
`define DELAY_STEP_CYC ((`DELAY_STEP_MS * `CLK_HZ) / 1000)
`define PWR_DELAY_MAX 6'h32
`endif

// ### core/axis_guard_pkg.sv
// Types shared by the axis guard files
package axis_guard_pkg;
    // Power sequencing states
    typedef enum logic [1:0] {
        PWR_OFF,
        PWR_ON,
        PWR_DELAY
    } pwr_state_e;
    // Limit verdict bundle
    typedef struct packed {
        logic fwd_hit;
        logic rev_hit;
        logic tgt_fwd;
        logic tgt_rev;
    } limit_flags_s;
endpackage

// ### core/soft_limit_check.sv
// Comparator for axis position and target against the software limits
`timescale 1ns/10ps
module soft_limit_check #(
    parameter int W = 32
) (
    input wire logic signed [W-1:0] i_position,
    input wire logic signed [W-1:0] i_target,
    input wire logic signed [W-1:0] i_fwd_limit,
    input wire logic signed [W-1:0] i_rev_limit,
    input wire logic i_fwd_en,
    input wire logic i_rev_en,
    input wire logic i_ref_ok,
    input wire logic i_tgt_chk,
    output axis_guard_pkg::limit_flags_s o_flags
);
    // Strictly beyond the limit counts as crossed
    always_comb begin
        o_flags.fwd_hit = i_ref_ok && i_fwd_en && (i_position > i_fwd_limit); // RQ20
        o_flags.rev_hit = i_ref_ok && i_rev_en && (i_position < i_rev_limit); // RQ20
        o_flags.tgt_fwd = i_ref_ok && i_fwd_en && i_tgt_chk && (i_target > i_fwd_limit);
        o_flags.tgt_rev = i_ref_ok && i_rev_en && i_tgt_chk && (i_target < i_rev_limit);
    end
endmodule // soft_limit_check

// ### core/power_off_timer.sv
// Counts brake-to-power-off delay steps of one divided tick each
`timescale 1ns/10ps
module power_off_timer #(
    parameter int STEP_CYC = 400000
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_start,
    input wire logic [5:0] i_steps,
    output logic o_busy,
    output logic o_done
);
    logic [18:0] div_reg;
    logic [18:0] div_next;
    logic [5:0] step_reg;
    logic [5:0] step_next;
    logic busy_reg;
    logic busy_next;
    logic done_next;
    logic done_reg;
    // Next-state for the step divider and step counter
    always_comb begin
        div_next = div_reg;
        step_next = step_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        if (i_start) begin
            // Zero steps ends at once
            div_next = '0;
            step_next = i_steps;
            busy_next = (i_steps != 6'h00);
            done_next = (i_steps == 6'h00);
        end else if (busy_reg) begin
            if (div_reg == 19'(STEP_CYC - 1)) begin
                div_next = '0;
                if (step_reg == 6'h01) begin
                    busy_next = 1'b0;
                    done_next = 1'b1;
                end
                step_next = step_reg - 6'h01;
            end else begin
                div_next = div_reg + 19'h00001;
            end
        end
    end
    // Registers only
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            div_reg <= '0;
            step_reg <= '0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            div_reg <= div_next;
            step_reg <= step_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
        end
    end
    assign o_busy = busy_reg;
    assign o_done = done_reg;
endmodule // power_off_timer

// ### core/axis_limit_brake_control.sv
// Software limit supervision and holding brake control with an APB register port
//
// Contract
// RQ1: Active limit crossing triggers overtravel emergency stop
// RQ2: Limits act only once reference is established
// RQ3: Enable digit: 0 both, 1 fwd, 2 rev, 3 none
// RQ4: Digit enables target screening, default off
// RQ5: Target beyond limit decelerates stop at limit
// RQ6: Signed limits, defaults plus/minus 1073741823
// RQ7: Host keeps reverse limit below forward limit
// RQ8: Brake output high releases, low applies brake
// RQ9: Alarm or servo-off applies the brake
// RQ10: Brake stays released during overtravel
// RQ11: Allocation digit routes brake, applied after restart
// RQ12: Functions sharing a terminal are ORed
// RQ13: Stopped motor: brake applies with servo-off
// RQ14: Power-off delay 0 to 50 steps of 10 ms
// RQ15: Alarm cuts motor power without delay
// RQ16: Delay alters timing only at standstill
// RQ17: Host waits release time plus 50 ms
// RQ18: Vertical axes: power off after brake engages
// RQ19: Soft limit raises overtravel warning when enabled; the code raises it only while motor power is on
// RQ20: Crossed means beyond forward or below reverse
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/10ps
`include "axis_guard_params.svh"
module axis_limit_brake_control #(
    parameter int STEP_CYC = `DELAY_STEP_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Host command strobes, same clock
    input wire logic i_home_return_cmd,
    input wire logic i_position_set_cmd,
    input wire logic i_position_set_reference_established_flag,
    input wire logic i_positioning_cmd,
    input wire logic i_interpolated_feed_cmd,
    input wire logic i_servo_power_on_cmd,
    input wire logic i_servo_power_off_cmd,
    // Motion state, same clock
    input wire logic signed [31:0] i_position,
    input wire logic signed [31:0] i_target,
    input wire logic i_motor_stopped,
    input wire logic i_alarm,
    input wire logic i_ot_warn_enable,
    // Overtravel pins from outside; other terminal functions on this clock
    input wire logic i_forward_travel_block_in,
    input wire logic i_reverse_travel_block_in,
    input wire logic [2:0] i_other_out_functions,
    // Outputs
    output logic o_emergency_stop,
    output logic o_decel_stop,
    output logic signed [31:0] o_stop_position,
    output logic o_overtravel_warning,
    output logic o_motor_power,
    output logic o_brake_release_out,
    output logic [2:0] o_io_connector_out
);
    logic [31:0] func_reg, func_next;
    logic signed [31:0] fwd_reg, fwd_next;
    logic signed [31:0] rev_reg, rev_next;
    logic [31:0] alloc_reg, alloc_next;
    logic [5:0] delay_reg, delay_next;
    logic [1:0] bk_sel_reg, bk_sel_next; // Allocation latched at restart
    logic reference_established_flag_reg, reference_established_flag_next; // Reference established
    logic warn_reg, warn_next;
    logic decel_reg, decel_next;
    logic signed [31:0] stop_pos_reg, stop_pos_next;
    logic [31:0] rdata_reg, rdata_next;
    logic brake_reg, brake_next;
    logic power_reg, power_next;
    logic warn_clr;
    axis_guard_pkg::pwr_state_e pst_reg, pst_next;
    axis_guard_pkg::limit_flags_s flags;
    logic [1:0] fwd_sync, rev_sync; // Overtravel pin synchronisers
    logic hw_ot;
    logic timer_start, timer_busy, timer_done;
    logic apb_wr, apb_rd, addr_ok;
    logic fwd_en, rev_en;

    // Pin synchronisers, active low pins mean travel blocked
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            fwd_sync <= 2'b11;
            rev_sync <= 2'b11;
        end else begin
            fwd_sync <= {fwd_sync[0], i_forward_travel_block_in};
            rev_sync <= {rev_sync[0], i_reverse_travel_block_in};
        end
    end
    assign hw_ot = !fwd_sync[1] || !rev_sync[1];

    // APB decode, zero-wait answer
    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && !penable && !pwrite;
    always_comb begin
        case (paddr)
            `OFS_LIMIT_FUNC, `OFS_FWD_LIMIT, `OFS_REV_LIMIT, `OFS_OUT_ALLOC,
            `OFS_PWR_DELAY, `OFS_CONTROL, `OFS_STATUS, `OFS_POSITION,
            `OFS_TARGET: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;
    assign prdata = rdata_reg;

    // Enable digit decode
    always_comb begin
        case (func_reg[`FLD_LIM_EN_LSB +: 2]) // RQ3
            2'h0: begin
                fwd_en = 1'b1;
                rev_en = 1'b1;
            end
            2'h1: begin
                fwd_en = 1'b1;
                rev_en = 1'b0;
            end
            2'h2: begin
                fwd_en = 1'b0;
                rev_en = 1'b1;
            end
            default: begin
                fwd_en = 1'b0;
                rev_en = 1'b0;
            end
        endcase
    end

    soft_limit_check #(
        .W(32)
    ) u_check (
        .i_position(i_position),
        .i_target(i_target),
        .i_fwd_limit(fwd_reg),
        .i_rev_limit(rev_reg),
        .i_fwd_en(fwd_en),
        .i_rev_en(rev_en),
        .i_ref_ok(reference_established_flag_reg), // RQ2
        .i_tgt_chk(func_reg[`FLD_REF_CHK_BIT]), // RQ4
        .o_flags(flags)
    );

    // Register file and limit state next values
    always_comb begin
        func_next = func_reg;
        fwd_next = fwd_reg;
        rev_next = rev_reg;
        alloc_next = alloc_reg;
        delay_next = delay_reg;
        bk_sel_next = bk_sel_reg;
        reference_established_flag_next = reference_established_flag_reg;
        rdata_next = rdata_reg;
        warn_clr = 1'b0;
        decel_next = decel_reg;
        stop_pos_next = stop_pos_reg;
        if (apb_wr) begin
            case (paddr)
                `OFS_LIMIT_FUNC: func_next = pwdata & 32'h0000_0103;
                `OFS_FWD_LIMIT: fwd_next = pwdata; // RQ6
                `OFS_REV_LIMIT: rev_next = pwdata; // RQ6
                `OFS_OUT_ALLOC: alloc_next = pwdata & 32'h0000_0300;
                `OFS_PWR_DELAY: begin
                    // Clamp to the documented range
                    if (pwdata[5:0] > `PWR_DELAY_MAX || pwdata[31:6] != 26'h0) begin
                        delay_next = `PWR_DELAY_MAX;
                    end else begin
                        delay_next = pwdata[5:0];
                    end
                end
                `OFS_CONTROL: begin
                    // Bit 0 restarts: latch allocation, bit 1 clears warning
                    if (pwdata[0]) begin
                        bk_sel_next = alloc_reg[`FLD_BK_ALLOC_LSB +: 2]; // RQ11
                    end
                    warn_clr = pwdata[1];
                end
                default: begin
                end
            endcase
        end
        if (apb_rd) begin
            case (paddr)
                `OFS_LIMIT_FUNC: rdata_next = func_reg;
                `OFS_FWD_LIMIT: rdata_next = fwd_reg;
                `OFS_REV_LIMIT: rdata_next = rev_reg;
                `OFS_OUT_ALLOC: rdata_next = alloc_reg;
                `OFS_PWR_DELAY: rdata_next = {26'h0, delay_reg};
                `OFS_STATUS: rdata_next = {23'h0, timer_busy, bk_sel_reg, power_reg, brake_reg,
                    warn_reg, decel_reg, o_emergency_stop, reference_established_flag_reg};
                `OFS_POSITION: rdata_next = i_position;
                `OFS_TARGET: rdata_next = i_target;
                default: rdata_next = 32'h0000_0000;
            endcase
        end
        // Reference established by homing or position set
        if (i_home_return_cmd) begin
            reference_established_flag_next = 1'b1; // RQ2
        end else if (i_position_set_cmd) begin
            reference_established_flag_next = i_position_set_reference_established_flag; // RQ2
        end
        // Target screening, stop at the limit position
        if ((i_positioning_cmd || i_interpolated_feed_cmd) && (flags.tgt_fwd || flags.tgt_rev)) begin
            decel_next = 1'b1; // RQ5
            stop_pos_next = flags.tgt_fwd ? fwd_reg : rev_reg; // RQ5
        end else if (i_positioning_cmd || i_interpolated_feed_cmd) begin
            decel_next = 1'b0;
        end
    end

    // Warning is sticky; a new crossing wins over a clear
    always_comb begin
        warn_next = warn_reg;
        if (warn_clr) begin
            warn_next = 1'b0;
        end
        if (i_ot_warn_enable && power_reg && (flags.fwd_hit || flags.rev_hit)) begin
            warn_next = 1'b1; // RQ19
        end
    end

    // Power and brake sequencing
    always_comb begin
        pst_next = pst_reg;
        brake_next = brake_reg;
        power_next = power_reg;
        timer_start = 1'b0;
        case (pst_reg)
            axis_guard_pkg::PWR_OFF: begin
                if (i_servo_power_on_cmd && !i_alarm) begin
                    pst_next = axis_guard_pkg::PWR_ON;
                    power_next = 1'b1;
                    brake_next = 1'b1; // RQ8
                end
            end
            axis_guard_pkg::PWR_ON: begin
                // Overtravel leaves the brake released
                if (i_alarm) begin
                    pst_next = axis_guard_pkg::PWR_OFF;
                    power_next = 1'b0; // RQ15
                    brake_next = 1'b0; // RQ9
                end else if (i_servo_power_off_cmd) begin
                    brake_next = 1'b0; // RQ13
                    if (i_motor_stopped) begin
                        pst_next = axis_guard_pkg::PWR_DELAY; // RQ16
                        timer_start = 1'b1; // RQ14
                    end else begin
                        pst_next = axis_guard_pkg::PWR_OFF;
                        power_next = 1'b0;
                    end
                end
            end
            axis_guard_pkg::PWR_DELAY: begin
                if (i_alarm || timer_done) begin
                    pst_next = axis_guard_pkg::PWR_OFF;
                    power_next = 1'b0; // RQ15
                end
            end
            default: begin
                pst_next = axis_guard_pkg::PWR_OFF;
                power_next = 1'b0;
                brake_next = 1'b0;
            end
        endcase
    end

    power_off_timer #(
        .STEP_CYC(STEP_CYC)
    ) u_timer (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_start(timer_start),
        .i_steps(delay_reg),
        .o_busy(timer_busy),
        .o_done(timer_done)
    );

    // Registers only
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            func_reg <= `RST_LIMIT_FUNC;
            fwd_reg <= `RST_FWD_LIMIT;
            rev_reg <= `RST_REV_LIMIT;
            alloc_reg <= `RST_OUT_ALLOC;
            delay_reg <= 6'(`RST_PWR_DELAY);
            bk_sel_reg <= 2'h1;
            reference_established_flag_reg <= 1'b0;
            warn_reg <= 1'b0;
            decel_reg <= 1'b0;
            stop_pos_reg <= 32'h0000_0000;
            rdata_reg <= 32'h0000_0000;
            brake_reg <= 1'b0;
            power_reg <= 1'b0;
            pst_reg <= axis_guard_pkg::PWR_OFF;
        end else begin
            func_reg <= func_next;
            fwd_reg <= fwd_next;
            rev_reg <= rev_next;
            alloc_reg <= alloc_next;
            delay_reg <= delay_next;
            bk_sel_reg <= bk_sel_next;
            reference_established_flag_reg <= reference_established_flag_next;
            warn_reg <= warn_next;
            decel_reg <= decel_next;
            stop_pos_reg <= stop_pos_next;
            rdata_reg <= rdata_next;
            brake_reg <= brake_next;
            power_reg <= power_next;
            pst_reg <= pst_next;
        end
    end

    // Same emergency stop as hardware overtravel
    assign o_emergency_stop = hw_ot || flags.fwd_hit || flags.rev_hit; // RQ1
    assign o_decel_stop = decel_reg;
    assign o_stop_position = stop_pos_reg;
    assign o_overtravel_warning = warn_reg;
    assign o_motor_power = power_reg;
    assign o_brake_release_out = brake_reg; // RQ10

    // Terminal routing, brake ORed with other functions
    always_comb begin
        o_io_connector_out = i_other_out_functions; // RQ12
        case (bk_sel_reg)
            2'h1: o_io_connector_out[0] = i_other_out_functions[0] | brake_reg; // RQ11
            2'h2: o_io_connector_out[1] = i_other_out_functions[1] | brake_reg; // RQ11
            2'h3: o_io_connector_out[2] = i_other_out_functions[2] | brake_reg; // RQ11
            default: o_io_connector_out = i_other_out_functions;
        endcase
    end
endmodule // axis_limit_brake_control

// ### verification/axis_limit_brake_control_monitor.sv
// Checker for the axis guard top-level ports
`timescale 1ns/10ps
module axis_limit_brake_control_monitor (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_servo_power_on_cmd,
    input wire logic i_servo_power_off_cmd,
    input wire logic i_positioning_cmd,
    input wire logic i_interpolated_feed_cmd,
    input wire logic i_motor_stopped,
    input wire logic i_alarm,
    input wire logic i_ot_warn_enable,
    input wire logic [2:0] i_other_out_functions,
    input wire logic o_emergency_stop,
    input wire logic o_decel_stop,
    input wire logic o_overtravel_warning,
    input wire logic o_motor_power,
    input wire logic o_brake_release_out,
    input wire logic [2:0] o_io_connector_out
);
    // One clock domain for all checks
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    alarm_off_a: assert property (
        i_alarm |=> !o_brake_release_out && !o_motor_power)
        else $error("alarm left brake or power on");
    stop_off_a: assert property (
        i_servo_power_off_cmd && i_motor_stopped && !i_alarm && o_brake_release_out
        |=> !o_brake_release_out && o_motor_power)
        else $error("stopped servo off timing wrong");
    move_off_a: assert property (
        i_servo_power_off_cmd && !i_motor_stopped && !i_alarm && o_brake_release_out
        |=> !o_motor_power && !o_brake_release_out)
        else $error("moving servo off was delayed");
    on_release_a: assert property (
        i_servo_power_on_cmd && !i_servo_power_off_cmd && !i_alarm && !o_motor_power
        |=> o_motor_power && o_brake_release_out)
        else $error("servo on did not release brake");
    ot_hold_a: assert property (
        o_emergency_stop && o_brake_release_out && !i_alarm && !i_servo_power_off_cmd
        |=> o_brake_release_out)
        else $error("brake applied during overtravel");
    decel_cause_a: assert property (
        $rose(o_decel_stop) |-> $past(i_positioning_cmd || i_interpolated_feed_cmd))
        else $error("decel stop without target command");
    warn_cause_a: assert property (
        $rose(o_overtravel_warning) |-> $past(i_ot_warn_enable))
        else $error("warning raised while disabled");
    or_keep_a: assert property (
        (o_io_connector_out & i_other_out_functions) == i_other_out_functions)
        else $error("terminal lost another function");
    bk_route_a: assert property (
        !o_brake_release_out |-> o_io_connector_out == i_other_out_functions)
        else $error("applied brake still on a terminal");
endmodule // axis_limit_brake_control_monitor

// ### verification/host_cmd_model.sv
// Host controller model that issues servo and motion strobes
`timescale 1ns/10ps
module host_cmd_model #(
    parameter int GUARD = 8
) (
    input wire logic i_clk,
    output logic [6:0] o_cmd
);
    // Bits: 0 home, 1 pos set, 2 positioning, 3 interp, 4 on, 5 off, 6 reference_established_flag
    initial o_cmd = 7'h00;
    // One-cycle strobe launched just after a rising edge
    task send(input int b, input logic reference_established_flag);
        @(posedge i_clk);
        o_cmd <= (7'h01 << b) | {reference_established_flag, 6'h00};
        @(posedge i_clk);
        o_cmd <= 7'h00;
    endtask
    // Servo on, then hold off motion until the brake has released
    task servo_on();
        send(4, 1'b0);
        repeat (GUARD) @(posedge i_clk);
    endtask
endmodule // host_cmd_model

// ### verification/axis_limit_brake_control_bench.sv
// Self-checking bench for the axis guard
`timescale 1ns/10ps
module axis_limit_brake_control_bench;
    localparam int STEP = 10;
    logic i_clk, i_rst_b, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic signed [31:0] pos, tgt, stop_pos;
    logic stopped, alarm, warn_en, estop, decel, warn, power, brake;
    logic [2:0] other, io, prev, exp_io;
    logic [1:0] pin_b;
    logic [6:0] cmd;
    int mismatches, n_tests, n;
    // Device under test, travel pins driven active low
    axis_limit_brake_control #(.STEP_CYC(STEP)) u_dut (.i_clk, .i_rst_b, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .i_home_return_cmd(cmd[0]), .i_position_set_cmd(cmd[1]),
        .i_position_set_reference_established_flag(cmd[6]), .i_positioning_cmd(cmd[2]),
        .i_interpolated_feed_cmd(cmd[3]), .i_servo_power_on_cmd(cmd[4]),
        .i_servo_power_off_cmd(cmd[5]), .i_position(pos), .i_target(tgt),
        .i_motor_stopped(stopped), .i_alarm(alarm), .i_ot_warn_enable(warn_en),
        .i_forward_travel_block_in(pin_b[0]), .i_reverse_travel_block_in(pin_b[1]),
        .i_other_out_functions(other), .o_emergency_stop(estop), .o_decel_stop(decel),
        .o_stop_position(stop_pos), .o_overtravel_warning(warn), .o_motor_power(power),
        .o_brake_release_out(brake), .o_io_connector_out(io));
    host_cmd_model #(.GUARD(8)) u_host (.i_clk(i_clk), .o_cmd(cmd));
    // Clock at 40 MHz
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    // Compare and count
    task chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            mismatches++;
            $display("[ERR] %0t seen %h exp %h", $time, s, e);
        end
    endtask
    // Verdict and end of run
    task summarize();
        if (mismatches == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // One APB transfer, waits for pready under a bound
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge i_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge i_clk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge i_clk);
            if (pready === 1'b1) break;
        end
        if (k == 20) begin
            mismatches++;
            summarize();
        end
        rdv = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // Reset held for 5 cycles
    task rst();
        i_rst_b <= 1'b0;
        repeat (5) @(posedge i_clk);
        i_rst_b <= 1'b1;
    endtask
    // Reset values and an unmapped address
    task t_reset();
        logic [31:0] rv [5];
        rv = '{32'h3, 32'h3FFFFFFF, 32'hC0000001, 32'h100, 32'h0};
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 12'(i * 4), 32'h0);
            chk(rdv, rv[i]);
        end
        apb(1'b0, 12'h040, 32'h0);
        chk(err, 1'b1);
        chk(rdv, 32'h0);
        // Overtravel pins reach the stop after two flops
        @(posedge i_clk) pin_b <= 2'b10;
        repeat (2) @(negedge i_clk);
        chk(estop, 0);
        @(negedge i_clk) chk(estop, 1);
        @(posedge i_clk) pin_b <= 2'b01;
        repeat (3) @(negedge i_clk);
        chk(estop, 1);
        @(posedge i_clk) pin_b <= 2'b11;
    endtask
    // Limit window of plus/minus 100 with both limits on
    task limits();
        apb(1'b1, 12'h004, 32'd100);
        apb(1'b1, 12'h008, -32'sd100);
        apb(1'b1, 12'h000, 32'h0);
    endtask
    // Limit crossing, reference gating and enable digits
    task t_limits();
        limits();
        @(posedge i_clk) pos <= 101;
        @(negedge i_clk) chk(estop, 0);
        u_host.send(1, 1'b0);
        @(negedge i_clk) chk(estop, 0);
        u_host.send(0, 1'b0);
        @(negedge i_clk) chk(estop, 1);
        chk(brake, 1);
        @(posedge i_clk) pos <= 100;
        @(negedge i_clk) chk(estop, 0);
        for (int d = 0; d < 4; d++) begin
            apb(1'b1, 12'h000, d);
            pos <= 101;
            @(negedge i_clk) chk(estop, d < 2);
            @(posedge i_clk) pos <= -101;
            @(negedge i_clk) chk(estop, d == 0 || d == 2);
        end
        chk(warn, 1);
        // Cleared warning stays clear while detection is off
        @(posedge i_clk) warn_en <= 1'b0;
        apb(1'b1, 12'h014, 32'h2);
        apb(1'b1, 12'h000, 32'h0);
        repeat (2) @(negedge i_clk);
        chk({estop, warn}, 2'b10);
        @(posedge i_clk) rst();
        limits();
        pos <= 101;
        u_host.send(1, 1'b1);
        @(negedge i_clk) chk(estop, 1);
        @(posedge i_clk) pos <= 0;
    endtask
    // Target screening against the limits
    task aim(input int b, input logic signed [31:0] t, input logic e);
        @(posedge i_clk) tgt <= t;
        u_host.send(b, 1'b0);
        @(negedge i_clk) chk(decel, e);
    endtask
    task t_target();
        apb(1'b1, 12'h000, 32'h100);
        aim(2, 150, 1);
        chk(stop_pos, 100);
        aim(2, 50, 0);
        aim(3, -150, 1);
        chk(stop_pos, -100);
        apb(1'b1, 12'h000, 32'h0);
        aim(2, 150, 0);
    endtask
    // Brake and power sequencing
    task t_brake();
        apb(1'b1, 12'h010, 32'h3);
        stopped <= 1'b1;
        u_host.servo_on();
        @(negedge i_clk) chk({brake, power}, 2'b11);
        u_host.send(5, 1'b0);
        @(negedge i_clk) chk(brake, 0);
        for (n = 0; power === 1'b1 && n < 200; n++) @(negedge i_clk);
        chk(n >= 3 * STEP - 1 && n <= 3 * STEP + 3, 1);
        @(posedge i_clk) stopped <= 1'b0;
        u_host.servo_on();
        u_host.send(5, 1'b0);
        @(negedge i_clk) chk({brake, power}, 2'b00);
        @(posedge i_clk) stopped <= 1'b1;
        u_host.servo_on();
        @(posedge i_clk) alarm <= 1'b1;
        @(posedge i_clk) alarm <= 1'b0;
        @(negedge i_clk) chk({brake, power}, 2'b00);
    endtask
    // Brake terminal allocation, applied on restart
    task t_alloc();
        u_host.servo_on();
        @(posedge i_clk) other <= 3'b010;
        prev = 3'b011;
        for (int a = 0; a < 4; a++) begin
            apb(1'b1, 12'h00C, a << 8);
            @(negedge i_clk) chk(io, prev);
            apb(1'b1, 12'h014, 32'h1);
            exp_io = other | ((a == 0) ? 3'b000 : 3'(1 << (a - 1)));
            @(negedge i_clk) chk(io, exp_io);
            prev = exp_io;
        end
        u_host.send(5, 1'b0);
        @(negedge i_clk) chk(io, 3'b010);
        // Alarm during the power-off delay cuts power at once
        @(posedge i_clk) alarm <= 1'b1;
        @(posedge i_clk) alarm <= 1'b0;
        @(negedge i_clk) chk(power, 0);
    endtask
    // Main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {pos, tgt, stopped, alarm, other} = '0;
        pin_b = 2'b11;
        warn_en = 1'b1;
        mismatches = 0;
        n_tests = 0;
        rst();
        t_reset();
        u_host.servo_on();
        t_limits();
        t_target();
        t_brake();
        t_alloc();
        summarize();
    end
    // Watchdog on the whole run
    initial begin
        #2500000;
        mismatches++;
        summarize();
    end
endmodule // axis_limit_brake_control_bench
bind axis_limit_brake_control axis_limit_brake_control_monitor u_mon (.i_clk, .i_rst_b,
    .i_servo_power_on_cmd, .i_servo_power_off_cmd, .i_positioning_cmd,
    .i_interpolated_feed_cmd, .i_motor_stopped, .i_alarm, .i_ot_warn_enable,
    .i_other_out_functions, .o_emergency_stop, .o_decel_stop, .o_overtravel_warning,
    .o_motor_power, .o_brake_release_out, .o_io_connector_out);
